// ### rtl/sampler_pkg.sv
/*
 * shared constants for the synchronous sample capture block: control latch
 * and status port bit positions, reset values, converter timing, capture
 * states.
 * assumes a single 50 MHz clock and synchronous strobes from the generator.
 */
package sampler_pkg;

    localparam int ADDR_W = 8;
    localparam int WORD_W = 12;
    localparam int NIB_W = 4;
    localparam int NIB_N = WORD_W / NIB_W;
    localparam int HOST_DW = 16;
    localparam int CTRL_W = 8;
    localparam int STAT_W = 4;

    // sampler_control_latch fields
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_ARM_BIT = 1;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_AUX_LSB = 3;
    localparam int CTRL_AUX_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h02;

    // sampler_status_port fields
    localparam int STAT_ADDR_LSB_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_BOX_LSB = 2;
    localparam int STAT_BOX_W = 2;

    // converter timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_US = 35;
    localparam int CONV_CYCLES =
        (CONV_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = $clog2(CONV_CYCLES + 1);
    localparam int SAMPLE_PERIOD_US = 39;

    typedef enum logic [1:0] {
        CAP_IDLE = 2'b00,
        CAP_ARMED = 2'b01,
        CAP_RUN = 2'b11,
        CAP_DONE = 2'b10
    } cap_state_t;

endpackage

// ### rtl/sample_addr_counter.sv
/*
 * presettable sample address counter with synchronous clear.
 * assumes load, clear and increment are one-cycle synchronous requests.
 */
`timescale 1ns/1ps
module sample_addr_counter #(
    parameter int W = 8
) (
    input wire logic mclk_i,          // system clock
    input wire logic rstn_i,          // async reset, active low
    input wire logic load_i,          // follow preset value
    input wire logic [W-1:0] load_val_i, // preset value
    input wire logic clear_i,         // force to zero
    input wire logic inc_i,           // advance by one
    output logic [W-1:0] count_o      // current address
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load_i) begin
            count_d = load_val_i;
        end else if (clear_i) begin
            count_d = '0;
        end else if (inc_i) begin
            // natural wrap from all ones to zero [R19]
            count_d = count_q + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_o = count_q;
endmodule

// ### rtl/nibble_ram.sv
/*
 * one slice of sample storage: flip-flop memory with a synchronous write
 * port and an asynchronous read port.
 * assumes write enable is a one-cycle pulse.
 */
`timescale 1ns/1ps
module nibble_ram #(
    parameter int AW = 8,
    parameter int DW = 4
) (
    input wire logic mclk_i,          // system clock
    input wire logic we_i,            // write enable
    input wire logic [AW-1:0] waddr_i, // write address
    input wire logic [DW-1:0] wdata_i, // write data
    input wire logic [AW-1:0] raddr_i, // read address
    output logic [DW-1:0] rdata_o     // read data
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_q[raddr_i];
endmodule

// ### rtl/sample_capture.sv
/*
 * control logic of the audio digitizer: control latch, status port,
 * ping-pong hold select, converter sequencing, address counter, single
 * frame capture and host readout of 256 twelve-bit samples.
 * assumes host bus and generator strobes are synchronous to mclk_i and
 * that generator strobes are one-cycle pulses.
 */
`timescale 1ns/1ps
// Contract
// (R01) conversion strobe sets ready flag, status bit 1; sample read clears it
// (R02) status bit 0 mirrors address counter lsb
// (R03) sampling runs only while control bit 2 is one, audio path selected
// (R04) control bit 2 zero resets hold toggle, routes battery current
// (R05) hold toggle flips on every conversion strobe, swapping capacitors
// (R06) converter gives 12 bits at once; allow 35 us per conversion
// (R07) storage is three 4-bit memories sharing one address
// (R08) 8-bit presettable counter advances on each sample clock, every 39 us
// (R09) with control bit 0 high, frame start clears counter; else ignored
// (R10) host arms capture by pulsing control bit 1 low briefly
// (R11) first frame start begins capture, next ends it: one frame
// (R12) no new capture until a fresh arming pulse
// (R13) host sets address, read high, buffer select before strobes
// (R14) host read with buffer select presets counter to host address
// (R15) read with all strobes drives addressed 12-bit word on data bus
// (R16) status bits 2 and 3 show battery box switches
// (R17) generator pulses frame start only at its 256-count wrap
// (R18) enable with strobe high reads result; strobe low starts conversion
// (R19) counter wraps from 255 to 0 without frame start
module sample_capture
    import sampler_pkg::*;
(
    input wire logic mclk_i,                      // 50 MHz clock
    input wire logic rstn_i,                      // async reset, active low
    input wire logic [sampler_pkg::ADDR_W-1:0] host_addr_i, // word address
    input wire logic host_rw_i,                   // 1 read, 0 write
    input wire logic buffer_select_line_i,        // sample buffer select
    input wire logic control_select_line_i,       // latch / status select
    input wire logic as_n_i,                      // address strobe, low
    input wire logic uds_n_i,                     // upper data strobe, low
    input wire logic lds_n_i,                     // lower data strobe, low
    input wire logic [sampler_pkg::CTRL_W-1:0] host_wdata_i, // write data
    output logic [sampler_pkg::HOST_DW-1:0] host_rdata_o, // read data
    output logic host_rdata_oe_o,                 // drive data bus
    input wire logic conv_strobe_i,               // conversion strobe pulse
    input wire logic conv_enable_i,               // converter enable pulse
    input wire logic sample_clk_i,                // sample clock pulse
    input wire logic frame_start_pulse_i,         // generator wrap pulse
    input wire logic [sampler_pkg::WORD_W-1:0] adc_data_i, // converter out
    output logic adc_start_o,                     // start conversion pulse
    output logic adc_read_o,                      // read result pulse
    input wire logic [sampler_pkg::STAT_BOX_W-1:0] batt_box_sw_i, // box type
    output logic hold_sel_o,                      // 0: cap a charges
    output logic audio_route_o,                   // audio to hold input
    output logic batt_route_o,                    // battery volts to readout
    output logic [sampler_pkg::CTRL_AUX_W-1:0] prescale_ctrl_o, // aux bits
    output logic capture_active_o                 // frame being written
);
    import sampler_pkg::*;

    // host access decode
    logic strobes_on;
    logic rd_sample;
    logic rd_status;
    logic wr_ctrl;
    logic rd_sample_q;
    logic wr_ctrl_q;
    logic rd_sample_start;
    logic wr_ctrl_start;

    // control and status
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic ready_q;
    logic ready_d;
    logic hold_sel_q;
    logic hold_sel_d;
    logic sampling_on;
    logic sync_mode;
    logic [STAT_W-1:0] status;

    // capture sequencing
    cap_state_t cap_q;
    cap_state_t cap_d;
    logic write_allowed;

    // converter sequencing
    logic [CONV_CNT_W-1:0] busy_q;
    logic [CONV_CNT_W-1:0] busy_d;
    logic pend_q;
    logic pend_d;
    logic adc_start_q;
    logic adc_start_d;
    logic adc_read_q;
    logic adc_read_d;
    logic start_req;
    logic read_req;
    logic read_now;

    // address and storage
    logic [ADDR_W-1:0] addr_cnt;
    logic [ADDR_W-1:0] ram_raddr;
    logic [WORD_W-1:0] ram_word;
    logic preset_load;
    logic cnt_clear;

    // host readout
    logic [HOST_DW-1:0] rdata_q;
    logic [HOST_DW-1:0] rdata_d;
    logic oe_q;
    logic oe_d;

    assign strobes_on = !as_n_i && !uds_n_i && !lds_n_i;
    // the host sets address and direction before strobes [R13]
    assign rd_sample = strobes_on && host_rw_i && buffer_select_line_i;
    assign rd_status = strobes_on && host_rw_i && control_select_line_i
        && !buffer_select_line_i;
    assign wr_ctrl = !as_n_i && !lds_n_i && !host_rw_i
        && control_select_line_i;
    assign rd_sample_start = rd_sample && !rd_sample_q;
    assign wr_ctrl_start = wr_ctrl && !wr_ctrl_q;

    assign sampling_on = ctrl_q[CTRL_RUN_BIT]; // [R03]
    assign sync_mode = ctrl_q[CTRL_SYNC_BIT];

    // control latch takes the lower byte once per write cycle
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl_start) begin
            ctrl_d = host_wdata_i;
        end
    end

    // ready flag: a strobe in the clearing cycle still sets it
    always_comb begin
        ready_d = ready_q;
        if (rd_sample_start) begin
            ready_d = 1'b0; // [R01]
        end
        if (conv_strobe_i && sampling_on) begin
            ready_d = 1'b1; // [R01]
        end
    end

    // ping-pong hold select, held clear while sampling is off
    always_comb begin
        hold_sel_d = hold_sel_q;
        if (!sampling_on) begin
            hold_sel_d = 1'b0; // [R04]
        end else if (conv_strobe_i) begin
            hold_sel_d = !hold_sel_q; // [R05]
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= CTRL_RESET;
            ready_q <= 1'b0;
            hold_sel_q <= 1'b0;
            rd_sample_q <= 1'b0;
            wr_ctrl_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ready_q <= ready_d;
            hold_sel_q <= hold_sel_d;
            rd_sample_q <= rd_sample;
            wr_ctrl_q <= wr_ctrl;
        end
    end

    // capture flip-flops: held armed while the arm bit is low, so a
    // frame start during the pulse cannot begin a capture early
    always_comb begin
        cap_d = cap_q;
        if (!ctrl_q[CTRL_ARM_BIT]) begin
            cap_d = CAP_ARMED; // [R10]
        end else begin
            case (cap_q)
                CAP_IDLE: cap_d = CAP_IDLE;
                CAP_ARMED: begin
                    if (frame_start_pulse_i) begin
                        cap_d = CAP_RUN; // [R11]
                    end
                end
                CAP_RUN: begin
                    if (frame_start_pulse_i) begin
                        cap_d = CAP_DONE; // [R11]
                    end
                end
                CAP_DONE: cap_d = CAP_DONE; // [R12]
                default: cap_d = CAP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_q <= CAP_IDLE;
        end else begin
            cap_q <= cap_d;
        end
    end

    // free-running mode keeps writing circularly; synchronous mode
    // writes only the armed frame
    assign write_allowed = sampling_on
        && (!sync_mode || cap_q == CAP_RUN); // [R10] [R11]

    // converter: enable with strobe high reads, with strobe low starts
    assign start_req = conv_enable_i && !conv_strobe_i && sampling_on;
    assign read_req = conv_enable_i && conv_strobe_i && write_allowed;
    // a read arriving mid-conversion waits for the result [R06]
    assign read_now = (read_req || pend_q) && busy_q == '0;

    always_comb begin
        busy_d = busy_q;
        pend_d = (read_req || pend_q) && !read_now;
        adc_read_d = read_now;
        adc_start_d = 1'b0;
        if (busy_q != '0) begin
            busy_d = busy_q - 1'b1;
        end else if (start_req && !read_now) begin
            // a start while busy is dropped; the converter cannot
            // accept it anyway
            busy_d = CONV_CNT_W'(CONV_CYCLES); // [R06]
            adc_start_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_q <= '0;
            pend_q <= 1'b0;
            adc_start_q <= 1'b0;
            adc_read_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            pend_q <= pend_d;
            adc_start_q <= adc_start_d;
            adc_read_q <= adc_read_d;
        end
    end

    // host read with buffer select steers the counter [R14]
    assign preset_load = host_rw_i && buffer_select_line_i;
    assign cnt_clear = frame_start_pulse_i && sync_mode; // [R09]

    sample_addr_counter #(
        .W(ADDR_W)
    ) u_addr_cnt (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .load_i(preset_load),
        .load_val_i(host_addr_i),
        .clear_i(cnt_clear),
        .inc_i(sample_clk_i), // [R08]
        .count_o(addr_cnt)
    );

    // read port follows the host address at once, so the word is ready
    // in the same cycle the preset happens
    assign ram_raddr = preset_load ? host_addr_i : addr_cnt;

    // whole 12-bit result lands in one write across the slices [R06]
    for (genvar g = 0; g < NIB_N; g++) begin : g_slice
        nibble_ram #(
            .AW(ADDR_W),
            .DW(NIB_W)
        ) u_slice (
            .mclk_i(mclk_i),
            .we_i(adc_read_q),
            .waddr_i(addr_cnt),
            .wdata_i(adc_data_i[g*NIB_W +: NIB_W]),
            .raddr_i(ram_raddr),
            .rdata_o(ram_word[g*NIB_W +: NIB_W]) // [R07]
        );
    end

    assign status[STAT_ADDR_LSB_BIT] = addr_cnt[0]; // [R02]
    assign status[STAT_READY_BIT] = ready_q; // [R01]
    assign status[STAT_BOX_LSB +: STAT_BOX_W] = batt_box_sw_i; // [R16]

    // readout data and enable registered together
    always_comb begin
        rdata_d = rdata_q;
        oe_d = rd_sample || rd_status;
        if (rd_sample) begin
            rdata_d = {{(HOST_DW-WORD_W){1'b0}}, ram_word}; // [R15]
        end else if (rd_status) begin
            rdata_d = {{(HOST_DW-STAT_W){1'b0}}, status};
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= '0;
            oe_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            oe_q <= oe_d;
        end
    end

    assign host_rdata_o = rdata_q;
    assign host_rdata_oe_o = oe_q;
    assign adc_start_o = adc_start_q;
    assign adc_read_o = adc_read_q;
    assign hold_sel_o = hold_sel_q;
    assign audio_route_o = sampling_on; // [R03]
    assign batt_route_o = !sampling_on; // [R04]
    assign prescale_ctrl_o = ctrl_q[CTRL_AUX_LSB +: CTRL_AUX_W];
    assign capture_active_o = write_allowed;
endmodule

// ### verif/sample_capture_asserts.sv
/* port assertions for the sample capture block.
   bound to sample_capture; needs sampler_pkg compiled first. */
`timescale 1ns/1ps
module sample_capture_asserts
    import sampler_pkg::*;
(
    input wire logic mclk_i, // clock
    input wire logic rstn_i, // reset, low
    input wire logic host_rw_i, // 1 read
    input wire logic buffer_select_line_i, // sample select
    input wire logic control_select_line_i, // status select
    input wire logic as_n_i, // addr strobe
    input wire logic uds_n_i, // upper strobe
    input wire logic lds_n_i, // lower strobe
    input wire logic [sampler_pkg::CTRL_W-1:0] host_wdata_i, // write data
    input wire logic [sampler_pkg::HOST_DW-1:0] host_rdata_o, // data
    input wire logic host_rdata_oe_o, // data drive
    input wire logic conv_strobe_i, // conv strobe
    input wire logic conv_enable_i, // conv enable
    input wire logic [sampler_pkg::STAT_BOX_W-1:0] batt_box_sw_i, // box
    input wire logic adc_start_o, // start pulse
    input wire logic hold_sel_o, // hold select
    input wire logic audio_route_o, // run bit
    input wire logic batt_route_o, // battery path
    input wire logic capture_active_o // capturing
);
    logic rd_req;
    logic wr_req;
    logic [CONV_CNT_W-1:0] since_q;
    logic [CONV_CNT_W-1:0] since_d;

    assign rd_req = !as_n_i && !uds_n_i && !lds_n_i && host_rw_i
        && (buffer_select_line_i || control_select_line_i);
    // control write as the host presents it; only its first cycle counts
    assign wr_req = !as_n_i && !lds_n_i && !host_rw_i
        && control_select_line_i;

    // cycles since the last start, saturating at the conversion time
    always_comb begin
        since_d = since_q;
        if (adc_start_o) begin
            since_d = CONV_CNT_W'(1);
        end else if (since_q < CONV_CYCLES) begin
            since_d = since_q + CONV_CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_q <= CONV_CNT_W'(CONV_CYCLES);
        end else begin
            since_q <= since_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_read;
        rd_req;
    endsequence
    sequence s_status;
        rd_req && control_select_line_i && !buffer_select_line_i;
    endsequence

    a_oe_on: assert property (s_read |=> host_rdata_oe_o)
        else $error("data bus not driven after read");
    a_oe_off: assert property (!rd_req |=> !host_rdata_oe_o)
        else $error("data bus driven without read");
    a_upper_zero: assert property (host_rdata_oe_o |->
        host_rdata_o[15:12] == 4'h0)
        else $error("read word wider than twelve bits");
    a_box_status: assert property (s_status |=>
        host_rdata_o[3:2] == $past(batt_box_sw_i))
        else $error("status box bits wrong");
    a_route_pair: assert property (batt_route_o == !audio_route_o)
        else $error("battery and audio routes overlap");
    a_route_follow: assert property (wr_req && !$past(wr_req) |=>
        audio_route_o == $past(host_wdata_i[CTRL_RUN_BIT]))
        else $error("run bit not applied to audio route");
    a_hold_swap: assert property (audio_route_o && conv_strobe_i |=>
        hold_sel_o != $past(hold_sel_o))
        else $error("hold select did not toggle");
    a_hold_parked: assert property (!audio_route_o &&
        !$past(audio_route_o) |-> !hold_sel_o)
        else $error("hold select active while stopped");
    a_no_capture: assert property (!audio_route_o |->
        !capture_active_o)
        else $error("capture while sampling off");
    a_start_cause: assert property (adc_start_o |->
        $past(conv_enable_i) && !$past(conv_strobe_i)
        && $past(audio_route_o))
        else $error("conversion start without cause");
    a_conv_time: assert property (adc_start_o |->
        since_q >= CONV_CYCLES)
        else $error("conversion restarted too early");
endmodule

bind sample_capture sample_capture_asserts chk_i (.mclk_i, .rstn_i,
    .host_rw_i, .buffer_select_line_i, .control_select_line_i, .as_n_i,
    .uds_n_i, .lds_n_i, .host_rdata_o, .host_rdata_oe_o, .conv_strobe_i,
    .conv_enable_i, .batt_box_sw_i, .adc_start_o, .hold_sel_o,
    .audio_route_o, .batt_route_o, .capture_active_o, .host_wdata_i);

// ### verif/host_gen_model.sv
/* host bus and generator strobe model for the sample capture block.
   driven by bench task calls; lines change at the falling clock edge. */
`timescale 1ns/1ps
module host_gen_model
    import sampler_pkg::*;
(
    input wire logic mclk_i, // clock
    input wire logic [sampler_pkg::HOST_DW-1:0] rdata_i, // read data
    input wire logic oe_i, // data valid
    output logic [sampler_pkg::ADDR_W-1:0] addr_o, // word address
    output logic rw_o, // 1 read
    output logic bsel_o, // sample select
    output logic csel_o, // control select
    output logic as_n_o, // addr strobe
    output logic ds_n_o, // both data strobes
    output logic [sampler_pkg::CTRL_W-1:0] wdata_o, // write data
    output logic strobe_o, // conv strobe
    output logic enable_o, // conv enable
    output logic sclk_o, // sample clock
    output logic fstart_o, // frame start
    output logic [sampler_pkg::WORD_W-1:0] adc_o // converter result
);
    initial begin
        {addr_o, bsel_o, csel_o, wdata_o, adc_o} = '0;
        {strobe_o, enable_o, sclk_o, fstart_o} = 4'h0;
        {rw_o, as_n_o, ds_n_o} = 3'h7;
    end

    // released data lines show the inverse, not a stale copy
    task automatic wr_ctrl(input logic [CTRL_W-1:0] d);
        @(negedge mclk_i);
        {rw_o, csel_o, wdata_o} = {1'b0, 1'b1, d};
        {as_n_o, ds_n_o} = 2'h0;
        @(negedge mclk_i);
        {rw_o, csel_o, wdata_o} = {1'b1, 1'b0, ~d};
        {as_n_o, ds_n_o} = 2'h3;
        @(negedge mclk_i);
    endtask

    task automatic rd(input logic bs, input logic [ADDR_W-1:0] a,
        output logic [HOST_DW-1:0] d, output logic ok);
        ok = 1'b0;
        d = '0;
        @(negedge mclk_i);
        {addr_o, rw_o, bsel_o, csel_o} = {a, 1'b1, bs, !bs};
        @(negedge mclk_i);
        {as_n_o, ds_n_o} = 2'h0;
        repeat (4) begin
            if (!ok) begin
                @(posedge mclk_i);
                #1;
                ok = oe_i;
                d = rdata_i;
            end
        end
        @(negedge mclk_i);
        {as_n_o, ds_n_o, bsel_o, csel_o} = 4'hc;
        addr_o = ~a;
    endtask

    // frame start is commanded whenever sefc bit 0 is set, at any counter value
    task automatic pulse(input logic [3:0] sefc, input logic [WORD_W-1:0] v);
        @(negedge mclk_i);
        adc_o = v;
        {strobe_o, enable_o, sclk_o, fstart_o} = sefc;
        @(negedge mclk_i);
        {strobe_o, enable_o, sclk_o, fstart_o} = 4'h0;
    endtask
endmodule

// ### verif/tb_synchronous_sample_capture.sv
/* self-checking bench for the sample capture block.
   drives it through host_gen_model; battery box switches changed once, in the sync test. */
`timescale 1ns/1ps
module tb_synchronous_sample_capture
    import sampler_pkg::*;
;
    logic mclk_i, rstn_i, rw, bsel, csel, as_n, ds_n, oe;
    logic strobe, enable, sclk, fstart, st, rdp, hold, aud, batt, cap;
    logic [ADDR_W-1:0] addr;
    logic [CTRL_W-1:0] wdata;
    logic [WORD_W-1:0] adc;
    logic [HOST_DW-1:0] rdata, d;
    logic [CTRL_AUX_W-1:0] pre;
    logic [1:0] box_sw = 2'h2;
    int mismatches = 0;
    int n_tests = 0;

    sample_capture dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .host_addr_i(addr), .host_rw_i(rw), .buffer_select_line_i(bsel),
        .control_select_line_i(csel), .as_n_i(as_n), .uds_n_i(ds_n),
        .lds_n_i(ds_n), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .host_rdata_oe_o(oe), .conv_strobe_i(strobe), .conv_enable_i(enable),
        .sample_clk_i(sclk), .frame_start_pulse_i(fstart), .adc_data_i(adc),
        .adc_start_o(st), .adc_read_o(rdp), .batt_box_sw_i(box_sw),
        .hold_sel_o(hold), .audio_route_o(aud), .batt_route_o(batt),
        .prescale_ctrl_o(pre), .capture_active_o(cap));

    host_gen_model m (.mclk_i(mclk_i), .rdata_i(rdata), .oe_i(oe),
        .addr_o(addr), .rw_o(rw), .bsel_o(bsel), .csel_o(csel),
        .as_n_o(as_n), .ds_n_o(ds_n), .wdata_o(wdata), .strobe_o(strobe),
        .enable_o(enable), .sclk_o(sclk), .fstart_o(fstart), .adc_o(adc));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd(input logic bs, input logic [7:0] a);
        logic ok;
        m.rd(bs, a, d, ok);
        chk("read handshake", 16'h1, {15'h0, ok});
    endtask

    // status word: box, ready, counter lsb
    task automatic stat(input logic rdy, input logic lsb);
        rd(1'b0, 8'h00);
        chk("status", {12'h0, box_sw, rdy, lsb}, d);
    endtask

    task automatic t_reset();
        chk("battery route", 16'h1, {15'h0, batt});
        chk("capture active", 16'h0, {15'h0, cap});
        stat(1'b0, 1'b0);
        m.wr_ctrl(8'hfe);
        chk("aux bits", 16'h1f, {11'h0, pre});
        chk("audio route", 16'h1, {15'h0, aud});
        $display("test reset and control done");
    endtask

    task automatic t_hold();
        logic h;
        h = hold;
        m.pulse(4'h8, 12'h000);
        chk("hold swap", {15'h0, ~h}, {15'h0, hold});
        m.pulse(4'h8, 12'h000);
        chk("hold swap back", {15'h0, h}, {15'h0, hold});
        stat(1'b1, 1'b0);
        rd(1'b1, 8'h00);
        stat(1'b0, 1'b0);
        m.wr_ctrl(8'hfa);
        m.pulse(4'h8, 12'h000);
        chk("hold parked", 16'h0, {15'h0, hold});
        chk("capture off", 16'h0, {15'h0, cap});
        stat(1'b0, 1'b0);
        m.wr_ctrl(8'hfe);
        $display("test hold and ready done");
    endtask

    task automatic t_store();
        rd(1'b1, 8'hfe);
        stat(1'b0, 1'b0);
        m.pulse(4'h2, 12'h000);
        stat(1'b0, 1'b1);
        m.pulse(4'hc, 12'h5a3);
        chk("read pulse", 16'h1, {15'h0, rdp});
        rd(1'b1, 8'hff);
        chk("word at ff", 16'h05a3, d);
        m.pulse(4'h2, 12'h000);
        m.pulse(4'hc, 12'h3c6);
        rd(1'b1, 8'h00);
        chk("word after wrap", 16'h03c6, d);
        m.pulse(4'h4, 12'h000);
        chk("start pulse", 16'h1, {15'h0, st});
        m.pulse(4'h4, 12'h000);
        chk("start while busy", 16'h0, {15'h0, st});
        // a read request while busy must wait for the result
        m.pulse(4'hc, 12'h777);
        chk("read deferred", 16'h0, {15'h0, rdp});
        repeat (CONV_CYCLES + 20) @(negedge mclk_i);
        rd(1'b1, 8'h00);
        chk("deferred word", 16'h0777, d);
        $display("test store done");
    endtask

    task automatic t_sync();
        m.wr_ctrl(8'h05);
        m.wr_ctrl(8'h07);
        chk("armed idle", 16'h0, {15'h0, cap});
        rd(1'b1, 8'h05);
        m.pulse(4'h1, 12'h000);
        chk("capture run", 16'h1, {15'h0, cap});
        stat(1'b0, 1'b0);
        m.pulse(4'h2, 12'h000);
        m.pulse(4'hc, 12'h9e1);
        rd(1'b1, 8'h01);
        chk("captured word", 16'h09e1, d);
        m.pulse(4'h1, 12'h000);
        chk("capture end", 16'h0, {15'h0, cap});
        m.pulse(4'h1, 12'h000);
        chk("no restart", 16'h0, {15'h0, cap});
        m.wr_ctrl(8'h05);
        m.wr_ctrl(8'h07);
        m.pulse(4'h1, 12'h000);
        chk("rearmed run", 16'h1, {15'h0, cap});
        m.wr_ctrl(8'h06);
        rd(1'b1, 8'h03);
        m.pulse(4'h1, 12'h000);
        stat(1'b0, 1'b1);
        box_sw = 2'h1;
        stat(1'b0, 1'b1);
        $display("test sync capture done");
    endtask

    initial begin
        rstn_i = 1'b0;
        repeat (16) @(negedge mclk_i);
        rstn_i = 1'b1;
        t_reset();
        t_hold();
        t_store();
        t_sync();
        stop_test();
    end

    // the run needs about two thousand cycles; allow fifteen times that
    initial begin
        #(20 * 30000);
        mismatches++;
        stop_test();
    end
endmodule
